// ---- rssd_pkg.sv ----
package rssd_pkg;

    // ---------------------------------------------------------------
    // operation select codes
    // ---------------------------------------------------------------
    typedef enum logic [4:0] {
        OP_NONE                           = 5'h00,
        OP_ROTATE_LEFT_THRU_CARRY_MEM     = 5'h01,
        OP_ROTATE_LEFT_THRU_CARRY_TO_ACC  = 5'h02,
        OP_ROTATE_RIGHT_MEM               = 5'h03,
        OP_ROTATE_RIGHT_TO_ACC            = 5'h04,
        OP_ROTATE_RIGHT_THRU_CARRY_MEM    = 5'h05,
        OP_ROTATE_RIGHT_THRU_CARRY_TO_ACC = 5'h06,
        OP_MINUS_WITH_BORROW_TO_ACC       = 5'h07,
        OP_MINUS_WITH_BORROW_TO_MEM       = 5'h08,
        OP_MINUS_OPERAND_TO_ACC           = 5'h09,
        OP_MINUS_OPERAND_TO_MEM           = 5'h0A,
        OP_MINUS_IMMEDIATE_TO_ACC         = 5'h0B,
        OP_DECREMENT_SKIP_IF_NULL         = 5'h0C,
        OP_DECREMENT_TO_ACC_SKIP_IF_NULL  = 5'h0D,
        OP_INCREMENT_SKIP_IF_NULL         = 5'h0E,
        OP_INCREMENT_TO_ACC_SKIP_IF_NULL  = 5'h0F,
        OP_BIT_HIGH_SKIP                  = 5'h10,
        OP_SET_BYTE                       = 5'h11,
        OP_SET_BIT                        = 5'h12,
        OP_SWAP_NIBBLES                   = 5'h13
    } op_type;

    // ---------------------------------------------------------------
    // skip sequencer states
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_EXECUTE = 2'b01,
        ST_DUMMY   = 2'b10
    } state_type;

    localparam logic [7:0] ACC_RESET   = 8'h00;
    localparam logic       FLAG_RESET  = 1'b0;
    localparam logic [7:0] ALL_ONES    = 8'hFF;
    localparam logic [7:0] ONE_BYTE    = 8'h01;
    localparam int         SKIP_CYCLES = 2;
    localparam int         PLAIN_CYCLES = 1;

endpackage : rssd_pkg

// ---- rotate_subtract_skip_datapath.sv ----
`timescale 1ns/100ps
module rotate_subtract_skip_datapath #(
    parameter int WIDTH = 8
) (
    input  wire logic                  CORE_CLK,
    input  wire logic                  RST,
    input  wire logic                  OP_VALID,
    input  wire rssd_pkg::op_type      OP_CODE,
    input  wire logic [WIDTH-1:0]      MEM_DATA,
    input  wire logic [WIDTH-1:0]      IMM_DATA,
    input  wire logic [2:0]            BIT_SEL,
    output logic [WIDTH-1:0]           ACC,
    output logic                       CARRY_FLAG,
    output logic                       ZERO_FLAG,
    output logic                       HALF_CARRY_FLAG,
    output logic                       TWOS_COMPLEMENT_EXCESS_FLAG,
    output logic [WIDTH-1:0]           MEM_WDATA,
    output logic                       MEM_WRITE,
    output logic                       DISCARD_FETCH,
    output logic                       BUSY
);

    // ---------------------------------------------------------------
    // combinational result
    // ---------------------------------------------------------------
    logic [WIDTH-1:0] result;
    logic             to_acc;
    logic             to_mem;
    logic             new_carry;
    logic             arith;
    logic             skip;
    logic             take;
    logic [WIDTH:0]   sum;
    logic [4:0]       low_sum;
    logic [WIDTH-1:0] sub_b;
    logic             sub_cin;
    logic [WIDTH-1:0] bit_mask;
    rssd_pkg::state_type state;

    assign take     = OP_VALID && (state == rssd_pkg::ST_EXECUTE);
    assign bit_mask = rssd_pkg::ONE_BYTE << BIT_SEL;
    assign sub_b    = (OP_CODE == rssd_pkg::OP_MINUS_IMMEDIATE_TO_ACC) ? ~IMM_DATA : ~MEM_DATA;
    assign sub_cin  = (OP_CODE == rssd_pkg::OP_MINUS_WITH_BORROW_TO_ACC ||
                       OP_CODE == rssd_pkg::OP_MINUS_WITH_BORROW_TO_MEM) ? CARRY_FLAG : 1'b1;
    assign sum      = {1'b0, ACC} + {1'b0, sub_b} + {{WIDTH{1'b0}}, sub_cin};
    assign low_sum  = {1'b0, ACC[3:0]} + {1'b0, sub_b[3:0]} + {4'h0, sub_cin};

    always_comb begin
        result    = MEM_DATA;
        to_acc    = 1'b0;
        to_mem    = 1'b0;
        new_carry = CARRY_FLAG;
        arith     = 1'b0;
        skip      = 1'b0;
        case (OP_CODE)
            rssd_pkg::OP_ROTATE_LEFT_THRU_CARRY_MEM: begin
                result    = {MEM_DATA[WIDTH-2:0], CARRY_FLAG};
                new_carry = MEM_DATA[WIDTH-1];
                to_mem    = 1'b1;
            end
            rssd_pkg::OP_ROTATE_LEFT_THRU_CARRY_TO_ACC: begin
                result    = {MEM_DATA[WIDTH-2:0], CARRY_FLAG};
                new_carry = MEM_DATA[WIDTH-1];
                to_acc    = 1'b1;
            end
            rssd_pkg::OP_ROTATE_RIGHT_MEM: begin
                result = {MEM_DATA[0], MEM_DATA[WIDTH-1:1]};
                to_mem = 1'b1;
            end
            rssd_pkg::OP_ROTATE_RIGHT_TO_ACC: begin
                result = {MEM_DATA[0], MEM_DATA[WIDTH-1:1]};
                to_acc = 1'b1;
            end
            rssd_pkg::OP_ROTATE_RIGHT_THRU_CARRY_MEM: begin
                result    = {CARRY_FLAG, MEM_DATA[WIDTH-1:1]};
                new_carry = MEM_DATA[0];
                to_mem    = 1'b1;
            end
            rssd_pkg::OP_ROTATE_RIGHT_THRU_CARRY_TO_ACC: begin
                result    = {CARRY_FLAG, MEM_DATA[WIDTH-1:1]};
                new_carry = MEM_DATA[0];
                to_acc    = 1'b1;
            end
            rssd_pkg::OP_MINUS_WITH_BORROW_TO_ACC,
            rssd_pkg::OP_MINUS_OPERAND_TO_ACC,
            rssd_pkg::OP_MINUS_IMMEDIATE_TO_ACC: begin
                result    = sum[WIDTH-1:0];
                new_carry = sum[WIDTH];
                arith     = 1'b1;
                to_acc    = 1'b1;
            end
            rssd_pkg::OP_MINUS_WITH_BORROW_TO_MEM,
            rssd_pkg::OP_MINUS_OPERAND_TO_MEM: begin
                result    = sum[WIDTH-1:0];
                new_carry = sum[WIDTH];
                arith     = 1'b1;
                to_mem    = 1'b1;
            end
            rssd_pkg::OP_DECREMENT_SKIP_IF_NULL: begin
                result = MEM_DATA - rssd_pkg::ONE_BYTE;
                skip   = (result == '0);
                to_mem = 1'b1;
            end
            rssd_pkg::OP_DECREMENT_TO_ACC_SKIP_IF_NULL: begin
                result = MEM_DATA - rssd_pkg::ONE_BYTE;
                skip   = (result == '0);
                to_acc = 1'b1;
            end
            rssd_pkg::OP_INCREMENT_SKIP_IF_NULL: begin
                result = MEM_DATA + rssd_pkg::ONE_BYTE;
                skip   = (result == '0);
                to_mem = 1'b1;
            end
            rssd_pkg::OP_INCREMENT_TO_ACC_SKIP_IF_NULL: begin
                result = MEM_DATA + rssd_pkg::ONE_BYTE;
                skip   = (result == '0);
                to_acc = 1'b1;
            end
            rssd_pkg::OP_BIT_HIGH_SKIP: begin
                skip = MEM_DATA[BIT_SEL];
            end
            rssd_pkg::OP_SET_BYTE: begin
                result = rssd_pkg::ALL_ONES;
                to_mem = 1'b1;
            end
            rssd_pkg::OP_SET_BIT: begin
                result = MEM_DATA | bit_mask;
                to_mem = 1'b1;
            end
            rssd_pkg::OP_SWAP_NIBBLES: begin
                result = {MEM_DATA[3:0], MEM_DATA[WIDTH-1:4]};
                to_mem = 1'b1;
            end
            default: begin
                result = MEM_DATA;
            end
        endcase
    end

    // ---------------------------------------------------------------
    // skip sequencer
    // ---------------------------------------------------------------
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            state <= rssd_pkg::ST_EXECUTE;
        end else begin
            case (state)
                rssd_pkg::ST_EXECUTE: begin
                    if (take && skip) begin
                        state <= rssd_pkg::ST_DUMMY;
                    end
                end
                rssd_pkg::ST_DUMMY: begin
                    state <= rssd_pkg::ST_EXECUTE;
                end
                default: begin
                    state <= rssd_pkg::ST_EXECUTE;
                end
            endcase
        end
    end

    assign DISCARD_FETCH = (state == rssd_pkg::ST_DUMMY);
    assign BUSY          = (state == rssd_pkg::ST_DUMMY);

    // ---------------------------------------------------------------
    // accumulator
    // ---------------------------------------------------------------
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            ACC <= rssd_pkg::ACC_RESET;
        end else if (take && to_acc) begin
            ACC <= result;
        end
    end

    // ---------------------------------------------------------------
    // memory write port
    // ---------------------------------------------------------------
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            MEM_WRITE <= 1'b0;
            MEM_WDATA <= '0;
        end else begin
            MEM_WRITE <= take && to_mem;
            if (take && to_mem) begin
                MEM_WDATA <= result;
            end
        end
    end

    // ---------------------------------------------------------------
    // status flags
    // ---------------------------------------------------------------
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            CARRY_FLAG                  <= rssd_pkg::FLAG_RESET;
            ZERO_FLAG                   <= rssd_pkg::FLAG_RESET;
            HALF_CARRY_FLAG             <= rssd_pkg::FLAG_RESET;
            TWOS_COMPLEMENT_EXCESS_FLAG <= rssd_pkg::FLAG_RESET;
        end else if (take) begin
            CARRY_FLAG <= new_carry;
            if (arith) begin
                ZERO_FLAG                   <= (sum[WIDTH-1:0] == '0);
                HALF_CARRY_FLAG             <= low_sum[4];
                TWOS_COMPLEMENT_EXCESS_FLAG <= (ACC[WIDTH-1] == sub_b[WIDTH-1]) &&
                                               (sum[WIDTH-1] != ACC[WIDTH-1]);
            end
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    sequence skip_taken_s;
        take && skip;
    endsequence

    sequence dummy_then_back_s;
        DISCARD_FETCH ##1 !DISCARD_FETCH;
    endsequence

    dummy_cycle_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        skip_taken_s |=> dummy_then_back_s)
        else $error("skip did not give one dummy cycle");

    no_skip_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        (take && !skip) |=> !DISCARD_FETCH)
        else $error("dummy cycle without skip");

    rotate_carry_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        (take && OP_CODE == rssd_pkg::OP_ROTATE_LEFT_THRU_CARRY_MEM)
        |=> MEM_WRITE && MEM_WDATA == {$past(MEM_DATA[WIDTH-2:0]), $past(CARRY_FLAG)}
            && CARRY_FLAG == $past(MEM_DATA[WIDTH-1]))
        else $error("left rotate through carry wrong");

    right_carry_acc_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        (take && OP_CODE == rssd_pkg::OP_ROTATE_RIGHT_THRU_CARRY_TO_ACC)
        |=> !MEM_WRITE && ACC == {$past(CARRY_FLAG), $past(MEM_DATA[WIDTH-1:1])})
        else $error("right rotate through carry to acc wrong");

    rotate_flags_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        (take && OP_CODE == rssd_pkg::OP_ROTATE_RIGHT_MEM)
        |=> $stable(CARRY_FLAG) && $stable(ZERO_FLAG) && MEM_WDATA[WIDTH-1] == $past(MEM_DATA[0]))
        else $error("plain rotate changed flags");

    sub_result_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        (take && OP_CODE == rssd_pkg::OP_MINUS_OPERAND_TO_ACC)
        |=> ACC == $past(ACC) - $past(MEM_DATA) && CARRY_FLAG == ($past(ACC) >= $past(MEM_DATA)))
        else $error("subtract result or borrow wrong");

    set_byte_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        (take && OP_CODE == rssd_pkg::OP_SET_BYTE) |=> MEM_WRITE && MEM_WDATA == rssd_pkg::ALL_ONES)
        else $error("byte set wrong");

    swap_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        (take && OP_CODE == rssd_pkg::OP_SWAP_NIBBLES)
        |=> MEM_WDATA == {$past(MEM_DATA[3:0]), $past(MEM_DATA[WIDTH-1:4])} && $stable(CARRY_FLAG))
        else $error("nibble swap wrong");

    left_carry_acc_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        (take && OP_CODE == rssd_pkg::OP_ROTATE_LEFT_THRU_CARRY_TO_ACC)
        |=> !MEM_WRITE && ACC == {$past(MEM_DATA[WIDTH-2:0]), $past(CARRY_FLAG)}
            && CARRY_FLAG == $past(MEM_DATA[WIDTH-1]))
        else $error("left rotate through carry to acc wrong");

    right_carry_mem_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        (take && OP_CODE == rssd_pkg::OP_ROTATE_RIGHT_THRU_CARRY_MEM)
        |=> MEM_WRITE && MEM_WDATA == {$past(CARRY_FLAG), $past(MEM_DATA[WIDTH-1:1])}
            && CARRY_FLAG == $past(MEM_DATA[0]))
        else $error("right rotate through carry to memory wrong");

    borrow_acc_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        (take && OP_CODE == rssd_pkg::OP_MINUS_WITH_BORROW_TO_ACC)
        |=> ACC == $past(ACC) - $past(MEM_DATA) - WIDTH'(!$past(CARRY_FLAG)) && ZERO_FLAG == (ACC == '0))
        else $error("subtract with borrow to acc wrong");

    minus_mem_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        (take && OP_CODE == rssd_pkg::OP_MINUS_OPERAND_TO_MEM)
        |=> MEM_WRITE && $stable(ACC) && MEM_WDATA == $past(ACC) - $past(MEM_DATA)
            && ZERO_FLAG == ($past(ACC) == $past(MEM_DATA)))
        else $error("subtract to memory wrong");

    minus_immediate_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        (take && OP_CODE == rssd_pkg::OP_MINUS_IMMEDIATE_TO_ACC)
        |=> ACC == $past(ACC) - $past(IMM_DATA) && CARRY_FLAG == ($past(ACC) >= $past(IMM_DATA)))
        else $error("subtract immediate wrong");

    excess_flag_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        (take && OP_CODE == rssd_pkg::OP_MINUS_OPERAND_TO_ACC)
        |=> TWOS_COMPLEMENT_EXCESS_FLAG == (($past(ACC[WIDTH-1]) != $past(MEM_DATA[WIDTH-1]))
            && (ACC[WIDTH-1] != $past(ACC[WIDTH-1]))))
        else $error("signed excess of subtract wrong");

    borrow_carry_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        (take && OP_CODE == rssd_pkg::OP_MINUS_WITH_BORROW_TO_MEM)
        |=> CARRY_FLAG == ($past(ACC) > $past(MEM_DATA)
            || ($past(ACC) == $past(MEM_DATA) && $past(CARRY_FLAG))))
        else $error("carry of subtract with borrow wrong");

    dec_write_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        (take && OP_CODE == rssd_pkg::OP_DECREMENT_SKIP_IF_NULL)
        |=> MEM_WRITE && MEM_WDATA == $past(MEM_DATA) - rssd_pkg::ONE_BYTE && $stable(ZERO_FLAG)
            && DISCARD_FETCH == ($past(MEM_DATA) == rssd_pkg::ONE_BYTE))
        else $error("decrement and skip wrong");

    dec_acc_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        (take && OP_CODE == rssd_pkg::OP_DECREMENT_TO_ACC_SKIP_IF_NULL)
        |=> !MEM_WRITE && ACC == $past(MEM_DATA) - rssd_pkg::ONE_BYTE && $stable(CARRY_FLAG)
            && DISCARD_FETCH == (ACC == '0))
        else $error("decrement to acc and skip wrong");

    inc_write_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        (take && OP_CODE == rssd_pkg::OP_INCREMENT_SKIP_IF_NULL)
        |=> MEM_WRITE && MEM_WDATA == $past(MEM_DATA) + rssd_pkg::ONE_BYTE && $stable(CARRY_FLAG)
            && DISCARD_FETCH == ($past(MEM_DATA) == rssd_pkg::ALL_ONES))
        else $error("increment and skip wrong");

    inc_acc_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        (take && OP_CODE == rssd_pkg::OP_INCREMENT_TO_ACC_SKIP_IF_NULL)
        |=> !MEM_WRITE && ACC == $past(MEM_DATA) + rssd_pkg::ONE_BYTE && $stable(ZERO_FLAG)
            && DISCARD_FETCH == (ACC == '0))
        else $error("increment to acc and skip wrong");

    bit_skip_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        (take && OP_CODE == rssd_pkg::OP_BIT_HIGH_SKIP)
        |=> !MEM_WRITE && $stable(ACC) && DISCARD_FETCH == $past(MEM_DATA[BIT_SEL]))
        else $error("bit test skip wrong");

    set_bit_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        (take && OP_CODE == rssd_pkg::OP_SET_BIT)
        |=> MEM_WRITE && MEM_WDATA[$past(BIT_SEL)] && $stable(CARRY_FLAG)
            && (MEM_WDATA & ~$past(bit_mask)) == ($past(MEM_DATA) & ~$past(bit_mask)))
        else $error("bit set wrong");

    dummy_ignore_a: assert property (@(posedge CORE_CLK) disable iff (RST)
        DISCARD_FETCH |=> !MEM_WRITE && !DISCARD_FETCH && $stable(ACC) && $stable(CARRY_FLAG))
        else $error("op taken in dummy cycle");

endmodule : rotate_subtract_skip_datapath

// ---- rotate_subtract_skip_datapath_bench.sv ----
`timescale 1ns/100ps
`define CHK(what, exp, got) begin num_checks++; if ((got) !== (exp)) begin n_fail++; \
    $display("ERROR %s expected %h seen %h", what, exp, got); end end
module rotate_subtract_skip_datapath_bench;
    logic             CORE_CLK = 1'b0;
    logic             RST      = 1'b1;
    logic             OP_VALID = 1'b0;
    rssd_pkg::op_type OP_CODE  = rssd_pkg::OP_NONE;
    logic [7:0]       MEM_DATA = 8'h00;
    logic [7:0]       IMM_DATA = 8'h00;
    logic [2:0]       BIT_SEL  = 3'h0;
    logic [7:0]       ACC;
    logic [7:0]       MEM_WDATA;
    logic             CARRY_FLAG, ZERO_FLAG, HALF_CARRY_FLAG, TWOS_COMPLEMENT_EXCESS_FLAG;
    logic             MEM_WRITE, DISCARD_FETCH, BUSY;
    logic [7:0]       e_acc, e_wdata;
    logic             e_c, e_z, e_half, e_excess, e_wr, e_skip;
    logic [7:0]       edge_vals [5] = '{8'h00, 8'h01, 8'h7F, 8'h80, 8'hFF};
    int               n_fail     = 0;
    int               num_checks = 0;
    int               seed       = 72058;

    rotate_subtract_skip_datapath #(.WIDTH(8)) rotate_subtract_skip_datapath_i (
        .CORE_CLK(CORE_CLK), .RST(RST), .OP_VALID(OP_VALID), .OP_CODE(OP_CODE), .MEM_DATA(MEM_DATA),
        .IMM_DATA(IMM_DATA), .BIT_SEL(BIT_SEL), .ACC(ACC), .CARRY_FLAG(CARRY_FLAG), .ZERO_FLAG(ZERO_FLAG),
        .HALF_CARRY_FLAG(HALF_CARRY_FLAG), .TWOS_COMPLEMENT_EXCESS_FLAG(TWOS_COMPLEMENT_EXCESS_FLAG),
        .MEM_WDATA(MEM_WDATA), .MEM_WRITE(MEM_WRITE), .DISCARD_FETCH(DISCARD_FETCH), .BUSY(BUSY));

    initial begin
        forever #2 CORE_CLK = ~CORE_CLK;
    end

    // ---------------------------------------------------------------
    // expectation helpers
    // ---------------------------------------------------------------
    // returns {overflow, half carry, carry, result}
    function automatic logic [10:0] subtract(input logic [7:0] a, input logic [7:0] b, input logic cin);
        int borrow;
        int wide;
        int low;
        int signed_diff;
        borrow      = cin ? 0 : 1;
        wide        = int'(a) - int'(b) - borrow;
        low         = int'(a[3:0]) - int'(b[3:0]) - borrow;
        signed_diff = int'($signed(a)) - int'($signed(b)) - borrow;
        return {(signed_diff > 127) || (signed_diff < -128), low >= 0, wide >= 0, 8'(wide)};
    endfunction : subtract

    task automatic check_all;
        `CHK("ACC", e_acc, ACC)
        `CHK("CARRY_FLAG", e_c, CARRY_FLAG)
        `CHK("ZERO_FLAG", e_z, ZERO_FLAG)
        `CHK("HALF_CARRY_FLAG", e_half, HALF_CARRY_FLAG)
        `CHK("EXCESS_FLAG", e_excess, TWOS_COMPLEMENT_EXCESS_FLAG)
        `CHK("MEM_WDATA", e_wdata, MEM_WDATA)
        `CHK("MEM_WRITE", e_wr, MEM_WRITE)
        `CHK("DISCARD_FETCH", e_skip, DISCARD_FETCH)
        `CHK("BUSY", e_skip, BUSY)
    endtask : check_all

    // ---------------------------------------------------------------
    // drivers
    // ---------------------------------------------------------------
    task automatic run_op(input rssd_pkg::op_type op, input logic [7:0] m, input logic [7:0] imm,
                          input logic [2:0] bs, input logic valid);
        logic [10:0] s;
        logic [7:0]  r;
        logic        take;
        OP_VALID = valid;
        OP_CODE  = op;
        MEM_DATA = m;
        IMM_DATA = imm;
        BIT_SEL  = bs;
        take     = valid && !e_skip;
        e_wr     = 1'b0;
        e_skip   = 1'b0;
        r        = m;
        s        = 11'h000;
        if (take) begin
            case (op)
                rssd_pkg::OP_ROTATE_LEFT_THRU_CARRY_MEM, rssd_pkg::OP_ROTATE_LEFT_THRU_CARRY_TO_ACC: begin
                    r   = {m[6:0], e_c};
                    e_c = m[7];
                end
                rssd_pkg::OP_ROTATE_RIGHT_MEM, rssd_pkg::OP_ROTATE_RIGHT_TO_ACC: r = {m[0], m[7:1]};
                rssd_pkg::OP_ROTATE_RIGHT_THRU_CARRY_MEM, rssd_pkg::OP_ROTATE_RIGHT_THRU_CARRY_TO_ACC: begin
                    r   = {e_c, m[7:1]};
                    e_c = m[0];
                end
                rssd_pkg::OP_MINUS_WITH_BORROW_TO_ACC, rssd_pkg::OP_MINUS_WITH_BORROW_TO_MEM: s = subtract(e_acc, m, e_c);
                rssd_pkg::OP_MINUS_OPERAND_TO_ACC, rssd_pkg::OP_MINUS_OPERAND_TO_MEM: s = subtract(e_acc, m, 1'b1);
                rssd_pkg::OP_MINUS_IMMEDIATE_TO_ACC: s = subtract(e_acc, imm, 1'b1);
                rssd_pkg::OP_DECREMENT_SKIP_IF_NULL, rssd_pkg::OP_DECREMENT_TO_ACC_SKIP_IF_NULL: begin
                    r      = m - 8'h01;
                    e_skip = (r == 8'h00);
                end
                rssd_pkg::OP_INCREMENT_SKIP_IF_NULL, rssd_pkg::OP_INCREMENT_TO_ACC_SKIP_IF_NULL: begin
                    r      = m + 8'h01;
                    e_skip = (r == 8'h00);
                end
                rssd_pkg::OP_BIT_HIGH_SKIP: e_skip = m[bs];
                rssd_pkg::OP_SET_BYTE: r = 8'hFF;
                rssd_pkg::OP_SET_BIT: r = m | (8'h01 << bs);
                rssd_pkg::OP_SWAP_NIBBLES: r = {m[3:0], m[7:4]};
                default: r = m;
            endcase
            if (op inside {[rssd_pkg::OP_MINUS_WITH_BORROW_TO_ACC : rssd_pkg::OP_MINUS_IMMEDIATE_TO_ACC]}) begin
                {e_excess, e_half, e_c, r} = s;
                e_z = (r == 8'h00);
            end
            if (op inside {rssd_pkg::OP_ROTATE_LEFT_THRU_CARRY_MEM, rssd_pkg::OP_ROTATE_RIGHT_MEM,
                           rssd_pkg::OP_ROTATE_RIGHT_THRU_CARRY_MEM, rssd_pkg::OP_MINUS_WITH_BORROW_TO_MEM,
                           rssd_pkg::OP_MINUS_OPERAND_TO_MEM, rssd_pkg::OP_DECREMENT_SKIP_IF_NULL,
                           rssd_pkg::OP_INCREMENT_SKIP_IF_NULL, [rssd_pkg::OP_SET_BYTE : rssd_pkg::OP_SWAP_NIBBLES]}) begin
                e_wr    = 1'b1;
                e_wdata = r;
            end
            if (op inside {rssd_pkg::OP_ROTATE_LEFT_THRU_CARRY_TO_ACC, rssd_pkg::OP_ROTATE_RIGHT_TO_ACC,
                           rssd_pkg::OP_ROTATE_RIGHT_THRU_CARRY_TO_ACC, rssd_pkg::OP_MINUS_WITH_BORROW_TO_ACC,
                           rssd_pkg::OP_MINUS_OPERAND_TO_ACC, rssd_pkg::OP_MINUS_IMMEDIATE_TO_ACC,
                           rssd_pkg::OP_DECREMENT_TO_ACC_SKIP_IF_NULL, rssd_pkg::OP_INCREMENT_TO_ACC_SKIP_IF_NULL}) begin
                e_acc = r;
            end
        end
        @(posedge CORE_CLK);
        #1;
        check_all();
    endtask : run_op

    task automatic do_reset;
        RST     = 1'b1;
        e_acc   = rssd_pkg::ACC_RESET;
        e_wdata = 8'h00;
        {e_c, e_z, e_half, e_excess} = {4{rssd_pkg::FLAG_RESET}};
        {e_wr, e_skip} = 2'b00;
        repeat (20) @(posedge CORE_CLK);
        #1;
        check_all();
        RST = 1'b0;
    endtask : do_reset

    task automatic random_ops(input int count);
        repeat (count) begin
            run_op(rssd_pkg::op_type'(($random(seed) & 32'h7FFFFFFF) % 20), 8'($random(seed)),
                   8'($random(seed)), 3'($random(seed)), (($random(seed) & 3) != 0));
        end
    endtask : random_ops

    task automatic report_and_stop;
        if (n_fail == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : report_and_stop

    // ---------------------------------------------------------------
    // sequence
    // ---------------------------------------------------------------
    initial begin
        do_reset();
        // skip then an op offered in the dummy cycle
        run_op(rssd_pkg::OP_DECREMENT_SKIP_IF_NULL, 8'h01, 8'h00, 3'h0, 1'b1);
        run_op(rssd_pkg::OP_SET_BYTE, 8'h00, 8'h00, 3'h0, 1'b1);
        run_op(rssd_pkg::OP_INCREMENT_TO_ACC_SKIP_IF_NULL, 8'hFF, 8'h00, 3'h0, 1'b1);
        for (int k = 0; k < 20; k++) begin
            foreach (edge_vals[j]) begin
                run_op(rssd_pkg::op_type'(k), edge_vals[j], edge_vals[4 - j], 3'(k), 1'b1);
            end
        end
        for (int i = 0; i < 8; i++) begin
            run_op(rssd_pkg::OP_BIT_HIGH_SKIP, 8'h01 << i, 8'h00, 3'(i), 1'b1);
            run_op(rssd_pkg::OP_BIT_HIGH_SKIP, ~(8'h01 << i), 8'h00, 3'(i), 1'b1);
            run_op(rssd_pkg::OP_SET_BIT, 8'h5A, 8'h00, 3'(i), 1'b1);
        end
        random_ops(3000);
        do_reset();
        random_ops(2000);
        report_and_stop();
    end

    initial begin
        repeat (50000) @(posedge CORE_CLK);
        n_fail++;
        report_and_stop();
    end
endmodule : rotate_subtract_skip_datapath_bench
